/* inc/mevirq_pkg.sv */
// motion event interrupt and fault guard: shared constants and types
// assumes a 16-bit peripheral data bus and a single 10 MHz device clock
package mevirq_pkg;

  // ==========================================================
  // bus widths and frame placement
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int OFF_W = 6;
  localparam logic [15:0] FRAME_BASE = 16'h7400;
  localparam logic [15:0] FRAME_LAST = 16'h743F;

  // ==========================================================
  // register offsets inside the 64-word frame
  localparam logic [5:0] OFF_COMPARE_CONTROL_REG = 6'h11;
  localparam logic [5:0] OFF_CAPTURE_FIFO_STATUS = 6'h22;
  localparam logic [5:0] OFF_MASK_A = 6'h2C;
  localparam logic [5:0] OFF_MASK_B = 6'h2D;
  localparam logic [5:0] OFF_MASK_C = 6'h2E;
  localparam logic [5:0] OFF_FLAG_A = 6'h2F;
  localparam logic [5:0] OFF_FLAG_B = 6'h30;
  localparam logic [5:0] OFF_FLAG_C = 6'h31;

  // ==========================================================
  // event groups and field layout
  localparam int A_W = 11;
  localparam int B_W = 4;
  localparam int C_W = 3;
  localparam int FAULT_BIT = 0;
  localparam logic [10:0] MASK_A_RST = 11'h001;
  localparam logic [3:0] MASK_B_RST = 4'h0;
  localparam logic [2:0] MASK_C_RST = 3'h0;
  localparam int CAPF_LSB = 8;
  localparam int CAPF_W = 6;
  localparam logic [1:0] CAPF_FULL = 2'h2;
  localparam logic [15:0] COMPARE_CONTROL_REG_RST = 16'h0000;
  localparam int EV_PINS = 8;

  // ==========================================================
  // timing: fault qualification latency
  localparam int CLK_NS = 100;
  localparam int QUAL_NS = 200;
  localparam int QUAL_CYC = (QUAL_NS + CLK_NS - 1) / CLK_NS;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } mevirq_bus_s;

  typedef struct packed {
    logic [DATA_W-1:0] compare_control_reg;
    logic [CAPF_W-1:0] capf;
    logic [DATA_W-1:0] rdata;
    logic [EV_PINS-1:0] ev_out;
  } mevirq_state_s;

endpackage

/* rtl/mevirq_sync.sv */
// motion event fault input qualifier: two-stage synchroniser and fall detect
// assumes the fault pin idles high and is active low
`timescale 1ns/1ps
`default_nettype none
module mevirq_sync (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fault pin and qualified fall
  input wire logic pin_i,
  output logic fall_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
  } mevirq_sync_s;

  mevirq_sync_s q;
  mevirq_sync_s next_q;

  // ==========================================================
  // synchroniser chain, s2 and s3 feed the edge detector
  always_comb begin
    next_q = q;
    next_q.s1 = pin_i;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= 3'b111;
    end else begin
      q <= next_q;
    end
  end

  assign fall_o = q.s3 & ~q.s2;

endmodule
`default_nettype wire

/* rtl/mevirq_grp.sv */
// motion event interrupt group: flag and mask pair with write-one-to-clear
// assumes write strobes are already qualified by the frame select
`timescale 1ns/1ps
`default_nettype none
module mevirq_grp #(
  parameter int W = 4,
  parameter logic [W-1:0] MASK_RST = '0
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register access
  input wire logic mask_wr_i,
  input wire logic flag_wr_i,
  input wire logic [15:0] wdata_i,
  // events and state
  input wire logic [W-1:0] set_i,
  output logic [15:0] mask_o,
  output logic [15:0] flag_o,
  output logic req_o
);

  localparam int DW = mevirq_pkg::DATA_W;

  typedef struct packed {
    logic [W-1:0] mask;
    logic [W-1:0] flag;
  } mevirq_grp_s;

  mevirq_grp_s q;
  mevirq_grp_s next_q;

  // ==========================================================
  // flags are sticky, cleared by writing one, set wins over clear
  always_comb begin
    next_q = q;
    if (mask_wr_i) begin
      next_q.mask = wdata_i[W-1:0];
    end
    next_q.flag = (q.flag & ~(flag_wr_i ? wdata_i[W-1:0] : '0)) | set_i;
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= {MASK_RST, {W{1'b0}}};
    end else begin
      q <= next_q;
    end
  end

  assign mask_o = DW'(q.mask);
  assign flag_o = DW'(q.flag);
  assign req_o = |(q.flag & q.mask);

endmodule
`default_nettype wire

/* rtl/mevirq_top.sv */
// motion event interrupt and fault guard: register frame, event flags,
// group requests toward the interrupt expansion controller, fault tristate
// assumes synchronous inputs, one 10 MHz clock, vectoring done outside
//
// Functional notes
// - unmasked fault pin low tristates all event outputs at once, unsynchronised
// - fault flag sets after a two-cycle qualified, synchronised falling edge
// - fault flag sets on every qualified fall, masked or not
// - fault flag set and unmasked keeps outputs tristated and raises request
// - fault interrupt comes out of reset unmasked
// - only low six address bits decoded, and only while frame selected
// - register frame sits at 7400h through 743Fh
// - undefined registers and bits read zero, writes to them ignored
// - event condition sets its flag, flag holds until software clears
// - mask bit one unmasks its event, zero masks it
// - request raised whenever a flag and its mask are both set
// - three event groups, each tied to one of cpu lines two to four
// - flag cleared only by writing one; nothing clears on vector read
// - one request per group and one enable per flag, no vectoring here
// - capture flag sets only when that unit fifo already holds values
// - capture fifo status is read-write, bits seven to zero and fifteen to fourteen reserved
// - compare control takes effect after a single write
//
// Chosen here: the placing of the registers and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module mevirq_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire mevirq_pkg::mevirq_bus_s bus_i,
  output logic [mevirq_pkg::DATA_W-1:0] rdata_o,
  // event sources
  input wire logic power_fault_input_i,
  input wire logic [mevirq_pkg::A_W-2:0] evt_a_i,
  input wire logic [mevirq_pkg::B_W-1:0] evt_b_i,
  input wire logic [mevirq_pkg::C_W-1:0] cap_evt_i,
  input wire logic [mevirq_pkg::C_W-1:0] cap_pop_i,
  // event block pins
  input wire logic [mevirq_pkg::EV_PINS-1:0] ev_out_i,
  input wire logic [mevirq_pkg::EV_PINS-1:0] ev_en_i,
  output logic [mevirq_pkg::EV_PINS-1:0] ev_out_o,
  output logic [mevirq_pkg::EV_PINS-1:0] ev_oe_o,
  // requests and control
  output logic [2:0] irq_req_o,
  output logic [mevirq_pkg::DATA_W-1:0] compare_control_o
);

  // ==========================================================
  // helpers

  // registers that exist inside the frame
  function automatic logic off_known(input logic [5:0] off);
    logic hit;
    hit = 1'b0;
    case (off)
      mevirq_pkg::OFF_COMPARE_CONTROL_REG,
      mevirq_pkg::OFF_CAPTURE_FIFO_STATUS,
      mevirq_pkg::OFF_MASK_A,
      mevirq_pkg::OFF_MASK_B,
      mevirq_pkg::OFF_MASK_C,
      mevirq_pkg::OFF_FLAG_A,
      mevirq_pkg::OFF_FLAG_B,
      mevirq_pkg::OFF_FLAG_C: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // two-level fifo fill count, saturating at full
  function automatic logic [1:0] fifo_cnt(input logic [1:0] c, input logic push,
                                          input logic pop);
    logic [1:0] n;
    n = c;
    if (push && !pop && c != mevirq_pkg::CAPF_FULL) begin
      n = c + 2'h1;
    end else if (pop && !push && c != 2'h0) begin
      n = c - 2'h1;
    end
    return n;
  endfunction

  // ==========================================================
  // declarations
  mevirq_pkg::mevirq_state_s q;
  mevirq_pkg::mevirq_state_s next_q;
  logic sel;
  logic [mevirq_pkg::OFF_W-1:0] off;
  logic wr;
  logic rd;
  logic fault_fall;
  logic hiz;
  logic [mevirq_pkg::C_W-1:0] cap_set;
  logic [mevirq_pkg::DATA_W-1:0] mask_a;
  logic [mevirq_pkg::DATA_W-1:0] mask_b;
  logic [mevirq_pkg::DATA_W-1:0] mask_c;
  logic [mevirq_pkg::DATA_W-1:0] flag_a;
  logic [mevirq_pkg::DATA_W-1:0] flag_b;
  logic [mevirq_pkg::DATA_W-1:0] flag_c;
  logic [mevirq_pkg::DATA_W-1:0] capf_rd;

  // ==========================================================
  // frame select and low-address decode
  assign sel = bus_i.addr[15:6] == mevirq_pkg::FRAME_BASE[15:6];
  assign off = bus_i.addr[mevirq_pkg::OFF_W-1:0];
  assign wr = bus_i.wr & sel;
  assign rd = bus_i.rd & sel;

  // ==========================================================
  // fault pin qualification
  mevirq_sync u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .pin_i(power_fault_input_i),
    .fall_o(fault_fall)
  );

  // ==========================================================
  // interrupt groups; bit n of irq_req_o drives cpu line n plus two
  mevirq_grp #(
    .W(mevirq_pkg::A_W),
    .MASK_RST(mevirq_pkg::MASK_A_RST)
  ) u_grp_a (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .mask_wr_i(wr && off == mevirq_pkg::OFF_MASK_A),
    .flag_wr_i(wr && off == mevirq_pkg::OFF_FLAG_A),
    .wdata_i(bus_i.wdata),
    .set_i({evt_a_i, fault_fall}),
    .mask_o(mask_a),
    .flag_o(flag_a),
    .req_o(irq_req_o[0])
  );

  mevirq_grp #(
    .W(mevirq_pkg::B_W),
    .MASK_RST(mevirq_pkg::MASK_B_RST)
  ) u_grp_b (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .mask_wr_i(wr && off == mevirq_pkg::OFF_MASK_B),
    .flag_wr_i(wr && off == mevirq_pkg::OFF_FLAG_B),
    .wdata_i(bus_i.wdata),
    .set_i(evt_b_i),
    .mask_o(mask_b),
    .flag_o(flag_b),
    .req_o(irq_req_o[1])
  );

  mevirq_grp #(
    .W(mevirq_pkg::C_W),
    .MASK_RST(mevirq_pkg::MASK_C_RST)
  ) u_grp_c (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .mask_wr_i(wr && off == mevirq_pkg::OFF_MASK_C),
    .flag_wr_i(wr && off == mevirq_pkg::OFF_FLAG_C),
    .wdata_i(bus_i.wdata),
    .set_i(cap_set),
    .mask_o(mask_c),
    .flag_o(flag_c),
    .req_o(irq_req_o[2])
  );

  // ==========================================================
  // fault tristate: pin path is immediate, flag path holds it
  assign hiz = mask_a[mevirq_pkg::FAULT_BIT] &
               (~power_fault_input_i | flag_a[mevirq_pkg::FAULT_BIT]);
  assign ev_oe_o = ev_en_i & ~{mevirq_pkg::EV_PINS{hiz}};
  assign ev_out_o = q.ev_out;

  // ==========================================================
  // capture status read image, reserved bits zero
  assign capf_rd = {{(mevirq_pkg::DATA_W - mevirq_pkg::CAPF_W){1'b0}}, q.capf}
                   << mevirq_pkg::CAPF_LSB;

  // ==========================================================
  // next state
  always_comb begin
    next_q = q;
    cap_set = '0;
    next_q.ev_out = ev_out_i;
    if (wr && off == mevirq_pkg::OFF_COMPARE_CONTROL_REG) begin
      next_q.compare_control_reg = bus_i.wdata;
    end
    for (int i = 0; i < mevirq_pkg::C_W; i++) begin
      cap_set[i] = cap_evt_i[i] && q.capf[2*i +: 2] != 2'h0;
      next_q.capf[2*i +: 2] = fifo_cnt(q.capf[2*i +: 2], cap_evt_i[i], cap_pop_i[i]);
    end
    if (wr && off == mevirq_pkg::OFF_CAPTURE_FIFO_STATUS) begin
      next_q.capf = bus_i.wdata[mevirq_pkg::CAPF_LSB +: mevirq_pkg::CAPF_W];
    end
    next_q.rdata = '0;
    if (rd) begin
      case (off)
        mevirq_pkg::OFF_COMPARE_CONTROL_REG: next_q.rdata = q.compare_control_reg;
        mevirq_pkg::OFF_CAPTURE_FIFO_STATUS: next_q.rdata = capf_rd;
        mevirq_pkg::OFF_MASK_A: next_q.rdata = mask_a;
        mevirq_pkg::OFF_MASK_B: next_q.rdata = mask_b;
        mevirq_pkg::OFF_MASK_C: next_q.rdata = mask_c;
        mevirq_pkg::OFF_FLAG_A: next_q.rdata = flag_a;
        mevirq_pkg::OFF_FLAG_B: next_q.rdata = flag_b;
        mevirq_pkg::OFF_FLAG_C: next_q.rdata = flag_c;
        default: next_q.rdata = '0;
      endcase
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q.compare_control_reg <= mevirq_pkg::COMPARE_CONTROL_REG_RST;
      q.capf <= '0;
      q.rdata <= '0;
      q.ev_out <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign rdata_o = q.rdata;
  assign compare_control_o = q.compare_control_reg;

  // ==========================================================
  // assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  fault_pin_hiz_a: assert property (
    (!power_fault_input_i && mask_a[mevirq_pkg::FAULT_BIT]) |-> ev_oe_o == '0
  ) else $error("fault pin low but outputs still enabled");

  fault_latency_a: assert property (
    power_fault_input_i ##1 !power_fault_input_i |-> ##3 flag_a[mevirq_pkg::FAULT_BIT]
  ) else $error("fault flag not set two cycles after qualified fall");

  fault_early_a: assert property (
    (!flag_a[mevirq_pkg::FAULT_BIT] && power_fault_input_i ##1 !power_fault_input_i
     && !wr && !fault_fall) |-> ##1 !flag_a[mevirq_pkg::FAULT_BIT]
  ) else $error("fault flag set before qualification");

  fault_masked_a: assert property (
    (!mask_a[mevirq_pkg::FAULT_BIT] && fault_fall) |=> flag_a[mevirq_pkg::FAULT_BIT]
  ) else $error("masked fault did not set its flag");

  fault_hold_a: assert property (
    (flag_a[mevirq_pkg::FAULT_BIT] && mask_a[mevirq_pkg::FAULT_BIT])
    |-> (ev_oe_o == '0 && irq_req_o[0])
  ) else $error("fault flag not holding tristate and request");

  fault_reset_a: assert property (
    !$past(rst_n_i) |-> mask_a[mevirq_pkg::FAULT_BIT]
  ) else $error("fault not unmasked after reset");

  unsel_read_a: assert property (
    (bus_i.rd && !sel) |=> rdata_o == '0
  ) else $error("read answered without frame select");

  undef_read_a: assert property (
    (rd && !off_known(off)) |=> rdata_o == '0
  ) else $error("undefined register read not zero");

  flag_sticky_a: assert property (
    (flag_b != '0 && !wr) |=> (flag_b & $past(flag_b)) == $past(flag_b)
  ) else $error("flag dropped without software clear");

  group_req_a: assert property (
    ((flag_c & mask_c) != '0) |-> irq_req_o[2]
  ) else $error("flag and mask set but no request");

  flag_clear_a: assert property (
    (wr && off == mevirq_pkg::OFF_FLAG_B && bus_i.wdata == 16'hFFFF && evt_b_i == '0)
    |=> flag_b == '0
  ) else $error("write one did not clear flag");

  cap_first_a: assert property (
    (cap_evt_i[0] && q.capf[1:0] == 2'h0 && !flag_c[0] && !wr) |=> !flag_c[0]
  ) else $error("capture flag set with empty fifo");

  compare_control_reg_once_a: assert property (
    (wr && off == mevirq_pkg::OFF_COMPARE_CONTROL_REG) |=> compare_control_o == $past(bus_i.wdata)
  ) else $error("compare control not taken on single write");

  write_zero_a: assert property (
    (wr && off == mevirq_pkg::OFF_FLAG_A && bus_i.wdata == '0)
    |=> ($past(flag_a) & ~flag_a) == '0
  ) else $error("writing zero cleared a flag");

endmodule
`default_nettype wire

/* bench/mevirq_pie_model.sv */
// interrupt expansion controller model: records group requests, raises one cpu line
// assumes level requests from the event block and a one-cycle acknowledge
`timescale 1ns/1ps
`default_nettype none
module mevirq_pie_model #(
  parameter logic [7:0] VEC_BASE = 8'h30
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // requests and acknowledge
  input wire logic [2:0] req_i,
  input wire logic ack_i,
  // cpu side
  output logic [2:0] line_o,
  output logic [7:0] vector_o
);
  // ==========================================================
  // pending requests and priority
  logic [2:0] pend;
  logic [2:0] req_d;
  always_comb begin
    line_o = 3'h0;
    if (pend[0]) begin
      line_o = 3'h1;
    end else if (pend[1]) begin
      line_o = 3'h2;
    end else if (pend[2]) begin
      line_o = 3'h4;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend <= 3'h0;
      req_d <= 3'h0;
      vector_o <= 8'h00;
    end else begin
      // a standing level is recorded once, so an acknowledged group is not re-raised
      req_d <= req_i;
      pend <= (pend & ~(ack_i ? line_o : 3'h0)) | (req_i & ~req_d);
      if (ack_i && (line_o != 3'h0)) begin
        vector_o <= VEC_BASE + {6'h00, line_o[2], line_o[1]};
      end
    end
  end
endmodule
`default_nettype wire

/* bench/tb_mevirq_top.sv */
// testbench for the motion event interrupt and fault guard
// assumes the design files and the expansion controller model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_mevirq_top;
  localparam logic [7:0] VEC = 8'h30;
  logic clk_i;
  logic rst_n_i;
  mevirq_pkg::mevirq_bus_s bus_i;
  logic [15:0] rdata_o;
  logic pf_i;
  logic [9:0] evt_a_i;
  logic [3:0] evt_b_i;
  logic [2:0] cap_evt_i;
  logic [2:0] cap_pop_i;
  logic [7:0] ev_out_i;
  logic [7:0] ev_en_i;
  logic [7:0] ev_oe_o;
  logic [7:0] ev_out_o;
  logic [2:0] irq_req_o;
  logic [15:0] compare_control_o;
  logic ack;
  logic [2:0] cpu_line;
  logic [7:0] vec_id;
  logic [15:0] exp_q[$];
  logic rd_d;
  int fail_count;
  int check_count;
  int seed;
  int k;
  logic [15:0] v;

  // ==========================================================
  // design and partner
  mevirq_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .power_fault_input_i(pf_i), .evt_a_i(evt_a_i), .evt_b_i(evt_b_i),
    .cap_evt_i(cap_evt_i), .cap_pop_i(cap_pop_i), .ev_out_i(ev_out_i),
    .ev_en_i(ev_en_i), .ev_out_o(ev_out_o), .ev_oe_o(ev_oe_o), .irq_req_o(irq_req_o),
    .compare_control_o(compare_control_o));
  mevirq_pie_model #(.VEC_BASE(VEC)) u_pie (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .req_i(irq_req_o), .ack_i(ack), .line_o(cpu_line), .vector_o(vec_id));

  // ==========================================================
  // clock, checking and closing
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  always @(posedge clk_i) rd_d <= bus_i.rd;
  always @(negedge clk_i) begin
    if (rd_d) check("read data", rdata_o, exp_q.pop_front());
  end
  initial begin
    repeat (5000) @(posedge clk_i);
    fail_count++;
    results();
  end

  // ==========================================================
  // bus, event and fault drivers
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus_i <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] e);
    @(posedge clk_i);
    exp_q.push_back(e);
    bus_i <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
  endtask
  task automatic at();
    @(posedge clk_i);
    #1;
  endtask
  task automatic ev(input int g, input int b);
    @(posedge clk_i);
    if (g == 0) evt_a_i <= 10'h001 << b;
    else if (g == 1) evt_b_i <= 4'h1 << b;
    else cap_evt_i <= 3'h1 << b;
    @(posedge clk_i);
    evt_a_i <= '0;
    evt_b_i <= '0;
    cap_evt_i <= '0;
  endtask
  task automatic fault(input logic m);
    @(posedge clk_i);
    pf_i <= 1'b0;
    #1 check("pin enables", ev_oe_o, m ? 16'h0000 : 16'h00FF);
    @(posedge clk_i);
    pf_i <= 1'b1;
    at();
    check("fault req early", irq_req_o[0], 16'h0000);
    at();
    check("fault req", irq_req_o[0], m);
    check("fault pins", ev_oe_o, m ? 16'h0000 : 16'h00FF);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    seed = 21;
    rst_n_i = 1'b0;
    bus_i = '0;
    pf_i = 1'b1;
    evt_a_i = '0;
    evt_b_i = '0;
    cap_evt_i = '0;
    cap_pop_i = '0;
    ev_en_i = 8'hFF;
    ev_out_i = 8'($random(seed));
    ack = 1'b0;
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd(16'h742C, 16'h0001);
    rd(16'h742F, 16'h0000);
    rd(16'h7411, 16'h0000);
    v = 16'($random(seed));
    wr(16'h7411, v);
    rd(16'h7411, v);
    at();
    check("compare control", compare_control_o, v);
    @(posedge clk_i);
    ev_out_i <= v[7:0];
    at();
    check("event pins out", ev_out_o, v[7:0]);
    wr(16'h7403, 16'hFFFF);
    rd(16'h7403, 16'h0000);
    rd(16'h7451, 16'h0000);
    wr(16'h7811, 16'h0000);
    rd(16'h7411, v);
    wr(16'h742D, 16'hFFFF);
    rd(16'h742D, 16'h000F);
    wr(16'h742D, 16'h0000);
    fault(1'b1);
    rd(16'h742F, 16'h0001);
    wr(16'h742F, 16'h0001);
    rd(16'h742F, 16'h0000);
    wr(16'h742C, 16'h0000);
    fault(1'b0);
    rd(16'h742F, 16'h0001);
    wr(16'h742C, 16'h0001);
    at();
    check("fault hold req", irq_req_o, 16'h0001);
    check("fault hold pins", ev_oe_o, 16'h0000);
    wr(16'h742F, 16'h0001);
    for (int g = 0; g < 3; g++) begin
      k = {$random(seed)} % (g == 0 ? 10 : (g == 1 ? 4 : 3));
      v = (g == 0) ? (16'h0002 << k) : (16'h0001 << k);
      if (g == 2) begin
        ev(2, k);
        rd(16'h7431, 16'h0000);
        rd(16'h7422, 16'h0100 << (2 * k));
      end
      ev(g, k);
      rd(16'h742F + g, v);
      at();
      check("masked req", irq_req_o, 16'h0000);
      wr(16'h742C + g, 16'hFFFF);
      at();
      check("group req", irq_req_o, 16'h0001 << g);
      check("cpu line", cpu_line, 16'h0001 << g);
      @(posedge clk_i);
      ack <= 1'b1;
      @(posedge clk_i);
      ack <= 1'b0;
      at();
      check("vector id", vec_id, VEC + g);
      wr(16'h742F + g, 16'h0000);
      rd(16'h742F + g, v);
      wr(16'h742F + g, v);
      rd(16'h742F + g, 16'h0000);
      wr(16'h742C + g, (g == 0) ? 16'h0001 : 16'h0000);
    end
    wr(16'h7422, 16'hEAFF);
    rd(16'h7422, 16'h2A00);
    @(posedge clk_i);
    cap_pop_i <= 3'h1;
    @(posedge clk_i);
    cap_pop_i <= 3'h0;
    rd(16'h7422, 16'h2900);
    repeat (3) @(posedge clk_i);
    results();
  end
endmodule
`default_nettype wire
